// [shared/low_power_timer_pkg.sv]
// Package: register map, field positions, reset values and types of the low-power timer
`default_nettype none
package low_power_timer_pkg;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] PRE_OFF = 4'h4;
  localparam logic [3:0] CMP_OFF = 4'h8;
  localparam logic [3:0] CNT_OFF = 4'hC;
  localparam int unsigned CTL_EN_BIT = 0;
  localparam int unsigned CTL_PULSE_BIT = 1;
  localparam int unsigned CTL_FREE_BIT = 2;
  localparam int unsigned CTL_POL_BIT = 3;
  localparam int unsigned CTL_IE_BIT = 6;
  localparam int unsigned CTL_FLAG_BIT = 7;
  localparam int unsigned PRE_CS_LSB = 0;
  localparam int unsigned PRE_BYP_BIT = 2;
  localparam int unsigned PRE_VAL_LSB = 3;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [3:0] PRESCALE_RST = 4'h0;
  localparam logic [1:0] CS_RST = 2'h0;
  localparam logic [3:0] PRESCALE_MAX = 4'hF;
  localparam logic [4:0] DIV_SH_OFS = 5'h02;
  localparam logic [4:0] FILT_SH_OFS = 5'h01;
  localparam logic [4:0] DIV_SH_MAX = 5'h10;
  localparam logic [4:0] FILT_SH_MAX = 5'h0F;
  localparam logic [1:0] WARM_TICKS = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    WR_IDLE = 4'h1,
    WR_ADDR = 4'h2,
    WR_DATA = 4'h4,
    WR_RESP = 4'h8
  } wr_state_t;
endpackage
`default_nettype wire

// [src/sync_two_flop.sv]
// Two-flop synchroniser for slow clock and pulse levels entering the bus clock
`default_nettype none
module sync_two_flop #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule // sync_two_flop
`default_nettype wire

// [src/prefilter_core.sv]
// Shared prescaler and glitch filter producing one-cycle count pulses
`default_nettype none
module prefilter_core
  import low_power_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic pulse_mode,
  input wire logic bypass,
  input wire logic [3:0] prescale,
  input wire logic tick,
  input wire logic level,
  output logic inc
);
  logic [15:0] div_cnt_ff;
  logic filt_ff;
  logic prev_ff;
  logic inc_ff;
  logic [4:0] div_sh;
  logic [4:0] filt_sh;
  logic [15:0] term_div;
  logic [15:0] term_filt;
  logic filt_flip;
  logic [1:0] warm_ff;
  logic tick_ok;

  // Code 15 saturates so both lengths stay in their documented span
  assign div_sh = (prescale == PRESCALE_MAX) ? DIV_SH_MAX : (5'(prescale) + DIV_SH_OFS);
  assign filt_sh = (prescale == PRESCALE_MAX) ? FILT_SH_MAX : (5'(prescale) + FILT_SH_OFS);
  assign term_div = 16'((17'h00001 << div_sh) - 17'h00001);
  assign term_filt = 16'((17'h00001 << filt_sh) - 17'h00001);
  assign filt_flip = tick_ok && pulse_mode && (level != filt_ff) && (div_cnt_ff == term_filt);
  assign tick_ok = tick && (warm_ff == WARM_TICKS);

  // First two ticks after enable are swallowed, so a partial first slow period never counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warm_ff <= 2'h0;
    end else if (!run) begin
      warm_ff <= 2'h0;
    end else if (tick && (warm_ff != WARM_TICKS)) begin
      warm_ff <= warm_ff + 2'h1;
    end
  end

  // One counter serves as divider or as filter run length
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= CNT_RST;
    end else if (!run) begin
      div_cnt_ff <= CNT_RST;
    end else if (tick_ok) begin
      if (!pulse_mode) begin
        div_cnt_ff <= (div_cnt_ff == term_div) ? CNT_RST : div_cnt_ff + 16'h0001;
      end else begin
        div_cnt_ff <= (level == filt_ff || div_cnt_ff == term_filt) ? CNT_RST
                    : div_cnt_ff + 16'h0001;
      end
    end
  end

  // Filter output starts asserted on enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_ff <= 1'b1;
    end else if (!run) begin
      filt_ff <= 1'b1;
    end else if (filt_flip) begin
      filt_ff <= level;
    end
  end

  // Held asserted while idle so a high input gives no count at enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b1;
    end else if (!run) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= level;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inc_ff <= 1'b0;
    end else if (!run) begin
      inc_ff <= 1'b0;
    end else if (bypass) begin
      inc_ff <= pulse_mode ? (level && !prev_ff) : tick_ok;
    end else if (pulse_mode) begin
      inc_ff <= filt_flip && level;
    end else begin
      inc_ff <= tick_ok && (div_cnt_ff == term_div);
    end
  end

  assign inc = inc_ff;
endmodule // prefilter_core
`default_nettype wire

// [src/low_power_timer.sv]
// Top of the low-power timer: AXI4-Lite registers, counter, compare, trigger
// What this block does
// - One circuit: prescaler or glitch filter
// - Prescaled time mode counts every 2^2..2^16
// - First prescaled increment delayed one or two
// - Bypassed time mode counts every rising clock edge after the first two
// - Filter output starts asserted on enable
// - Filter follows input after 2^1..2^15 samples
// - Filtered pulses counted on filter output assertion
// - Unfiltered input forced asserted before enable
// - Match then increment: flag, trigger, clear unless free-running
// - Count clears on disable and overflow
// - Debug halt stops time mode, not pulse
// - Count register write captures snapshot for reads
// - Trigger rises with flag, never gated
// - Nonzero compare: trigger until next increment
// - Interrupt when flag and enable both set
// - Flag cleared by disable or write one
// - Enable and flag clear writable while running
// - Interrupt level needs no bus activity
// - Bypass bit routes raw clock or input
// - Two-bit select picks one of four clocks
// - Zero compare: trigger held until disable
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
module low_power_timer
  import low_power_timer_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] prescaler_clk_in,
  input wire logic pulse_in,
  input wire logic debug_halt,
  output logic timer_irq,
  output logic hw_trigger
);
  wr_state_t wr_state_ff;
  wr_state_t nxt_wr_state;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic en_ff;
  logic pulse_ff;
  logic free_ff;
  logic pol_ff;
  logic ie_ff;
  logic flag_ff;
  logic [1:0] cs_ff;
  logic byp_ff;
  logic [3:0] prescale_ff;
  logic [CNT_W-1:0] cmp_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] snap_ff;
  logic trig_ff;
  logic irq_ff;
  logic tick_prev_ff;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic ctl_wr;
  logic dis_now;
  logic [1:0] sync_q;
  logic tick;
  logic pre_inc;
  logic cnt_inc;
  logic match_inc;

  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs = s_axi_wvalid && wready_ff;
  assign wr_addr = (wr_state_ff == WR_ADDR) ? awaddr_ff : s_axi_awaddr;
  assign wr_data = (wr_state_ff == WR_DATA) ? wdata_ff : s_axi_wdata;
  assign wr_strb = (wr_state_ff == WR_DATA) ? wstrb_ff : s_axi_wstrb;
  assign wr_ok = (wr_addr == CTRL_OFF) || (wr_addr == PRE_OFF)
              || (wr_addr == CMP_OFF) || (wr_addr == CNT_OFF);
  assign ctl_wr = wr_fire && (wr_addr == CTRL_OFF) && wr_strb[0];
  assign dis_now = ctl_wr && !wr_data[CTL_EN_BIT];

  // Address and data are taken in either order
  always_comb begin
    nxt_wr_state = wr_state_ff;
    wr_fire = 1'b0;
    case (wr_state_ff)
      WR_IDLE: begin
        if (aw_hs && w_hs) begin
          nxt_wr_state = WR_RESP;
          wr_fire = 1'b1;
        end else if (aw_hs) begin
          nxt_wr_state = WR_ADDR;
        end else if (w_hs) begin
          nxt_wr_state = WR_DATA;
        end
      end
      WR_ADDR: begin
        if (w_hs) begin
          nxt_wr_state = WR_RESP;
          wr_fire = 1'b1;
        end
      end
      WR_DATA: begin
        if (aw_hs) begin
          nxt_wr_state = WR_RESP;
          wr_fire = 1'b1;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_state = WR_IDLE;
        end
      end
      default: nxt_wr_state = WR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_state_ff <= WR_IDLE;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      awready_ff <= (nxt_wr_state == WR_IDLE) || (nxt_wr_state == WR_DATA);
      wready_ff <= (nxt_wr_state == WR_IDLE) || (nxt_wr_state == WR_ADDR);
      bvalid_ff <= (nxt_wr_state == WR_RESP);
      if (wr_fire) begin
        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Control fields; software keeps setup steady while running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_ff <= 1'b0;
      pulse_ff <= 1'b0;
      free_ff <= 1'b0;
      pol_ff <= 1'b0;
      ie_ff <= 1'b0;
    end else if (ctl_wr) begin
      en_ff <= wr_data[CTL_EN_BIT];
      pulse_ff <= wr_data[CTL_PULSE_BIT];
      free_ff <= wr_data[CTL_FREE_BIT];
      pol_ff <= wr_data[CTL_POL_BIT];
      ie_ff <= wr_data[CTL_IE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_ff <= CS_RST;
      byp_ff <= 1'b0;
      prescale_ff <= PRESCALE_RST;
    end else if (wr_fire && (wr_addr == PRE_OFF) && wr_strb[0]) begin
      cs_ff <= wr_data[PRE_CS_LSB +: 2];
      byp_ff <= wr_data[PRE_BYP_BIT];
      prescale_ff <= wr_data[PRE_VAL_LSB +: 4];
    end
  end

  // Compare value is writable any time; the flag handshake is software's duty
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_ff <= CMP_RST;
    end else if (wr_fire && (wr_addr == CMP_OFF)) begin
      if (wr_strb[0]) begin
        cmp_ff[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        cmp_ff[15:8] <= wr_data[15:8];
      end
    end
  end

  // Any write to the count register takes a snapshot; the count itself is not loadable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_ff <= CNT_RST;
    end else if (wr_fire && (wr_addr == CNT_OFF)) begin
      snap_ff <= cnt_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h00000000;
      if (s_axi_araddr == CTRL_OFF) begin
        rdata_ff[CTL_EN_BIT] <= en_ff;
        rdata_ff[CTL_PULSE_BIT] <= pulse_ff;
        rdata_ff[CTL_FREE_BIT] <= free_ff;
        rdata_ff[CTL_POL_BIT] <= pol_ff;
        rdata_ff[CTL_IE_BIT] <= ie_ff;
        rdata_ff[CTL_FLAG_BIT] <= flag_ff;
      end else if (s_axi_araddr == PRE_OFF) begin
        rdata_ff[PRE_CS_LSB +: 2] <= cs_ff;
        rdata_ff[PRE_BYP_BIT] <= byp_ff;
        rdata_ff[PRE_VAL_LSB +: 4] <= prescale_ff;
      end else if (s_axi_araddr == CMP_OFF) begin
        rdata_ff[CNT_W-1:0] <= cmp_ff;
      end else if (s_axi_araddr == CNT_OFF) begin
        rdata_ff[CNT_W-1:0] <= snap_ff;
      end else begin
        rresp_ff <= RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // Selected clock and normalised input cross in via two flops
  sync_two_flop #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({pulse_in ^ pol_ff, prescaler_clk_in[cs_ff]}),
    .q(sync_q)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_prev_ff <= 1'b0;
    end else begin
      tick_prev_ff <= sync_q[0];
    end
  end

  // One tick per rising edge of the selected slow clock
  assign tick = sync_q[0] && !tick_prev_ff;

  prefilter_core u_prefilter (
    .clk(clk),
    .rst(rst),
    .run(en_ff),
    .pulse_mode(pulse_ff),
    .bypass(byp_ff),
    .prescale(prescale_ff),
    .tick(tick),
    .level(sync_q[1]),
    .inc(pre_inc)
  );

  assign cnt_inc = pre_inc && en_ff && !(debug_halt && !pulse_ff);
  assign match_inc = cnt_inc && (cnt_ff == cmp_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= CNT_RST;
    end else if (!en_ff || dis_now) begin
      cnt_ff <= CNT_RST;
    end else if (match_inc && !free_ff) begin
      cnt_ff <= CNT_RST;
    end else if (cnt_inc) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // A match in the same cycle as a write-one clear keeps the flag set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (!en_ff || dis_now) begin
      flag_ff <= 1'b0;
    end else if (match_inc) begin
      flag_ff <= 1'b1;
    end else if (ctl_wr && wr_data[CTL_FLAG_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_ff <= 1'b0;
    end else if (!en_ff || dis_now) begin
      trig_ff <= 1'b0;
    end else if (match_inc) begin
      trig_ff <= 1'b1;
    end else if (cnt_inc && (cmp_ff != CMP_RST)) begin
      trig_ff <= 1'b0;
    end
  end

  // Level output, stands without further bus traffic for wakeup use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && ie_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign timer_irq = irq_ff;
  assign hw_trigger = trig_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_on_match: assert property (match_inc && !dis_now |=> flag_ff)
    else $error("flag not set after match");
  a_trig_with_flag: assert property ($rose(flag_ff)
    |-> trig_ff && ($rose(trig_ff) || cmp_ff == CMP_RST))
    else $error("trigger did not rise with flag");
  a_cnt_idle_zero: assert property (!en_ff |-> cnt_ff == CNT_RST)
    else $error("count not zero while disabled");
  a_cnt_advance: assert property (cnt_inc && !dis_now && cnt_ff != cmp_ff
    |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("count did not advance by one");
  a_match_clear: assert property (match_inc && !free_ff && !dis_now |=> cnt_ff == CNT_RST)
    else $error("count not cleared on match");
  a_irq_follow: assert property (flag_ff && ie_ff ##1 flag_ff && ie_ff |-> timer_irq)
    else $error("interrupt missing");
  a_debug_stop: assert property (debug_halt && !pulse_ff && en_ff && !dis_now
    |=> $stable(cnt_ff))
    else $error("time count moved under debug halt");
  a_trig_zero_hold: assert property (trig_ff && cmp_ff == CMP_RST && en_ff && !dis_now
    |=> trig_ff)
    else $error("trigger dropped with zero compare");
  a_trig_release: assert property (trig_ff && cnt_inc && !match_inc && cmp_ff != CMP_RST
    |=> !trig_ff)
    else $error("trigger not released on increment");
  a_flag_w1c: assert property (flag_ff && ctl_wr && wr_data[CTL_FLAG_BIT] && !match_inc
    |=> !flag_ff)
    else $error("flag not cleared by write one");
  a_snap_capture: assert property (wr_fire && wr_addr == CNT_OFF
    |=> snap_ff == $past(cnt_ff))
    else $error("snapshot not captured");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  c_match: cover property (match_inc);
  c_zero_hold: cover property (trig_ff && cmp_ff == CMP_RST ##1 cnt_inc);
  c_snapshot_read: cover property (s_axi_rvalid && s_axi_rready && rdata_ff != 32'h00000000);
  c_free_wrap: cover property (free_ff && cnt_inc && cnt_ff == 16'hFFFF);
endmodule // low_power_timer
`default_nettype wire

// [dv/prescaler_clock_model.sv]
// Partner model: four free-running prescaler source clocks of distinct rates
`default_nettype none
module prescaler_clock_model (
  input wire logic clk,
  input wire logic rst,
  output logic [3:0] clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff [4];
  logic [3:0] src_ff;
  assign clk_out = src_ff;
  // Source i toggles every 4+i cycles: distinct periods expose a wrong select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= 4'h0;
        src_ff[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cnt_ff[i] == 4'(3 + i)) begin
          cnt_ff[i] <= 4'h0;
          src_ff[i] <= ~src_ff[i];
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 4'h1;
        end
      end
    end
  end
endmodule // prescaler_clock_model
`default_nettype wire

// [dv/test_low_power_timer.sv]
// Self-checking bench for the low-power timer over its register bus
`default_nettype none
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module test_low_power_timer
  import low_power_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pulse_in = 1'b0, debug_halt = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, timer_irq, hw_trigger;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] pclk;
  int err_count = 0;
  int n_compared = 0;
  longint cyc = 0;

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  prescaler_clock_model src_u (.clk(clk), .rst(rst), .clk_out(pclk));

  low_power_timer dut_u (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .prescaler_clk_in(pclk), .pulse_in(pulse_in), .debug_halt(debug_halt),
    .timer_irq(timer_irq), .hw_trigger(hw_trigger)
  );

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic hang;
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) hang();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic w(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK(r, RESP_OKAY)
  endtask

  task automatic rr(input logic [3:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
    `CHK(r, RESP_OKAY)
  endtask

  // Write-then-read, since the count is only visible through its capture
  task automatic snap(output logic [15:0] c);
    logic [31:0] d;
    w(CNT_OFF, 32'h0);
    rr(CNT_OFF, d);
    c = d[15:0];
  endtask

  // Prescale and compare move only while disabled, as software must ensure
  task automatic cfg(input logic [7:0] pre, input logic [15:0] cmp, input logic [7:0] ctl);
    w(CTRL_OFF, 32'h0);
    w(PRE_OFF, {24'h0, pre});
    w(CMP_OFF, {16'h0, cmp});
    w(CTRL_OFF, {24'h0, ctl});
  endtask

  task automatic wait_rise(output longint t);
    logic prev;
    int n;
    prev = 1'b1;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (prev === 1'b0 && hw_trigger === 1'b1) break;
      prev = hw_trigger;
    end
    if (n >= 3000) hang();
    t = cyc;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    `CHK(hw_trigger, 1'b0)
    `CHK(timer_irq, 1'b0)
    for (int i = 0; i < 4; i++) begin
      rr(4'(4 * i), d);
      `CHK(d, 32'h0)
    end
    wr(4'h6, 32'hFF, r);
    `CHK(r, RESP_SLVERR)
    rd(4'h6, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0)
  endtask

  task automatic t_bypass;
    longint t0, t1;
    for (int s = 0; s < 4; s++) begin
      cfg(8'h04 | 8'(s), 16'h0003, 8'h01);
      wait_rise(t0);
      wait_rise(t1);
      `CHK(t1 - t0, longint'(32 + 8 * s))
      repeat (5 + 2 * s) @(posedge clk);
      `CHK(hw_trigger, 1'b1)
      repeat (4) @(posedge clk);
      `CHK(hw_trigger, 1'b0)
    end
  endtask

  task automatic t_prescale;
    longint t0, t1;
    logic [31:0] d;
    logic [15:0] c;
    for (int p = 0; p < 2; p++) begin
      cfg(8'(p << 3), 16'h0001, 8'h01);
      wait_rise(t0);
      wait_rise(t1);
      `CHK(t1 - t0, longint'(64 << p))
    end
    cfg(8'h00, 16'h0000, 8'h01);
    t0 = cyc;
    wait_rise(t1);
    `CHK((t1 - t0 >= 40) && (t1 - t0 <= 52), 1'b1)
    repeat (100) @(posedge clk);
    `CHK(hw_trigger, 1'b1)
    w(CTRL_OFF, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(hw_trigger, 1'b0)
    rr(CTRL_OFF, d);
    `CHK(d[CTL_FLAG_BIT], 1'b0)
    snap(c);
    `CHK(c, 16'h0000)
  endtask

  task automatic t_irq;
    longint t;
    logic [31:0] d;
    logic [15:0] c;
    cfg(8'h04, 16'h0003, 8'h41);
    wait_rise(t);
    snap(c);
    `CHK(c, 16'h0000)
    `CHK(timer_irq, 1'b1)
    rr(CTRL_OFF, d);
    `CHK(d[CTL_FLAG_BIT], 1'b1)
    w(CTRL_OFF, 32'hC1);
    rr(CTRL_OFF, d);
    `CHK(d[CTL_FLAG_BIT], 1'b0)
    `CHK(timer_irq, 1'b0)
    w(CTRL_OFF, 32'h01);
    wait_rise(t);
    repeat (3) @(posedge clk);
    `CHK(timer_irq, 1'b0)
    rr(CTRL_OFF, d);
    `CHK(d[CTL_FLAG_BIT], 1'b1)
    cfg(8'h04, 16'h0003, 8'h05);
    wait_rise(t);
    snap(c);
    `CHK(c, 16'h0004)
  endtask

  task automatic t_debug;
    logic [31:0] d;
    logic [15:0] c, c2;
    cfg(8'h04, 16'hFFFF, 8'h01);
    repeat (40) @(posedge clk);
    snap(c);
    repeat (40) @(posedge clk);
    rr(CNT_OFF, d);
    `CHK(d[15:0], c)
    debug_halt <= 1'b1;
    repeat (20) @(posedge clk);
    snap(c);
    repeat (60) @(posedge clk);
    snap(c2);
    `CHK(c2, c)
    // Input already asserted at enable must not count
    pulse_in <= 1'b1;
    cfg(8'h04, 16'hFFFF, 8'h03);
    repeat (20) @(posedge clk);
    snap(c);
    `CHK(c, 16'h0000)
    repeat (3) begin
      pulse_in <= 1'b0;
      repeat (10) @(posedge clk);
      pulse_in <= 1'b1;
      repeat (10) @(posedge clk);
    end
    snap(c);
    `CHK(c, 16'h0003)
    debug_halt <= 1'b0;
  endtask

  task automatic t_filter;
    logic [15:0] c;
    // Active-low input already asserted at enable: filter starts asserted, no count
    pulse_in <= 1'b0;
    cfg(8'h00, 16'hFFFF, 8'h0B);
    repeat (60) @(posedge clk);
    snap(c);
    `CHK(c, 16'h0000)
    pulse_in <= 1'b1;
    repeat (60) @(posedge clk);
    pulse_in <= 1'b0;
    repeat (6) @(posedge clk);
    pulse_in <= 1'b1;
    repeat (60) @(posedge clk);
    snap(c);
    `CHK(c, 16'h0000)
    pulse_in <= 1'b0;
    repeat (80) @(posedge clk);
    pulse_in <= 1'b1;
    repeat (80) @(posedge clk);
    snap(c);
    `CHK(c, 16'h0001)
    w(CTRL_OFF, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bypass();
    t_prescale();
    t_irq();
    t_debug();
    t_filter();
    give_verdict();
  end
endmodule // test_low_power_timer
`default_nettype wire
